// >>> design/input_clock_select_hold_ctrl.sv
// Input clock selection, digital hold and output squelch control.
// Assumes a synchronous byte-wide register port and status inputs from the PLL.
//
// Functional notes
// - Manual register mode: field picks input one/two
// - Manual pin mode: external pin chooses input
// - Force hold overrides all selection controls
// - Squelch bit disables outputs during calibration
// - Method field: manual, nonrevertive, revertive, reserved
// - Five-bit history delay field feeds holdover
// - CMOS drive code sets output drive strength
// - Selection/hold register resets to 0x05
// - Method/history register resets to 0x12
// - Drive register resets to 0xed
// - Always-on bit bypasses calibration squelch
// - Drive code applies only with CMOS format
`timescale 1ns/1ps
module input_clock_select_hold_ctrl
  import clk_sel_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  input wire logic select_source_pin_mode,
  input wire logic external_select_pin,
  input wire logic output_always_on,
  input wire logic internal_calibration,
  input wire logic [2:0] output_one_format,
  input wire logic [2:0] output_two_format,
  input wire logic auto_choice,
  output logic input_select,
  output logic select_valid,
  output logic digital_hold,
  output logic auto_mode,
  output logic revertive,
  output logic [2:0] sel_mode,
  output logic clock_output_enable,
  output logic [4:0] history_delay,
  output logic [1:0] drive_one,
  output logic drive_one_valid,
  output logic [1:0] drive_two,
  output logic drive_two_valid
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] sel_hold;
  logic [7:0] method_hist;
  logic [7:0] cmos_drive;

  sel_hold_regfile u_regs (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(reg_wr_en),
    .rd_en(reg_rd_en),
    .addr(reg_addr),
    .wr_data(reg_wr_data),
    .rd_data(reg_rd_data),
    .sel_hold(sel_hold),
    .method_hist(method_hist),
    .cmos_drive(cmos_drive)
  );

  // Field extraction
  logic [1:0] active_input_select;
  logic force_digital_hold;
  logic squelch_during_calibration;
  logic [1:0] selection_method;
  logic [1:0] cmos_drive_strength;

  assign active_input_select = sel_hold[ACTIVE_SEL_LSB +: 2];
  assign force_digital_hold = sel_hold[FORCE_HOLD_BIT];
  assign squelch_during_calibration = sel_hold[SQUELCH_CAL_BIT];
  assign selection_method = method_hist[METHOD_LSB +: 2];
  assign cmos_drive_strength = cmos_drive[DRIVE_LSB +: 2];

  // ----------------------------------------
  // Per-output drive qualification
  // ----------------------------------------

  logic [2:0] out_format [2];
  logic out_is_cmos [2];
  logic [1:0] out_drive [2];

  assign out_format[0] = output_one_format;
  assign out_format[1] = output_two_format;

  // Drive code only means something to a CMOS buffer; other formats see zero
  for (genvar i = 0; i < 2; i++)
  begin : g_drive
    assign out_is_cmos[i] = (out_format[i] == FORMAT_CMOS);
    assign out_drive[i] = out_is_cmos[i] ? cmos_drive_strength : 2'h0;
  end

  // ----------------------------------------
  // Output state
  // ----------------------------------------
  typedef struct packed {
    logic input_select;
    logic select_valid;
    logic digital_hold;
    logic auto_mode;
    logic revertive;
    sel_mode_e mode;
    logic out_en;
    logic [4:0] hist;
    logic [1:0] drive_one;
    logic drive_one_valid;
    logic [1:0] drive_two;
    logic drive_two_valid;
  } ctrl_s;

  ctrl_s s;
  ctrl_s next_s;

  // ----------------------------------------
  // Selection decision
  // ----------------------------------------

  // Selection decision, squelch and drive qualification
  always_comb
  begin
    next_s = s;
    next_s.select_valid = 1'b0;
    next_s.digital_hold = 1'b0;
    next_s.auto_mode = 1'b0;
    next_s.revertive = 1'b0;
    if (force_digital_hold)
    begin
      // Last input choice is kept; input quality is not consulted
      next_s.digital_hold = 1'b1;
      next_s.mode = MODE_HOLD;
    end
    else
    begin
      case (selection_method)
        METHOD_MANUAL:
        begin
          next_s.select_valid = 1'b1;
          if (select_source_pin_mode)
          begin
            next_s.mode = MODE_MANUAL_PIN;
            next_s.input_select = external_select_pin;
          end
          else
          begin
            next_s.mode = MODE_MANUAL_REG;
            // Reserved codes leave the previous choice in place
            if (active_input_select == SEL_INPUT_ONE)
              next_s.input_select = 1'b0;
            else if (active_input_select == SEL_INPUT_TWO)
              next_s.input_select = 1'b1;
            else
              next_s.select_valid = 1'b0;
          end
        end
        METHOD_AUTO_NONREV:
        begin
          next_s.mode = MODE_AUTO_NONREV;
          next_s.auto_mode = 1'b1;
          next_s.select_valid = 1'b1;
          next_s.input_select = auto_choice;
        end
        METHOD_AUTO_REV:
        begin
          next_s.mode = MODE_AUTO_REV;
          next_s.auto_mode = 1'b1;
          next_s.revertive = 1'b1;
          next_s.select_valid = 1'b1;
          next_s.input_select = auto_choice;
        end
        default:
        begin
          next_s.mode = MODE_RESERVED;
        end
      endcase
    end
    // Outputs squelched during calibration when the squelch bit is set, unless always-on is set
    next_s.out_en = !(internal_calibration && squelch_during_calibration && !output_always_on);
    next_s.hist = method_hist[HISTORY_DELAY_LSB +: HISTORY_DELAY_W];
    // Drive code passes through only for CMOS-format outputs
    next_s.drive_one_valid = out_is_cmos[0];
    next_s.drive_two_valid = out_is_cmos[1];
    next_s.drive_one = out_drive[0];
    next_s.drive_two = out_drive[1];
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '{input_select: 1'b0, select_valid: 1'b0, digital_hold: 1'b0, auto_mode: 1'b0,
             revertive: 1'b0, mode: MODE_MANUAL_REG, out_en: 1'b1, hist: RST_METHOD_HIST[HISTORY_DELAY_LSB +: HISTORY_DELAY_W],
             drive_one: 2'h0, drive_one_valid: 1'b0, drive_two: 2'h0, drive_two_valid: 1'b0};
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Port drive
  // ----------------------------------------

  // Every output except reg_rd_data is a field of the registered state word
  assign input_select = s.input_select;
  assign select_valid = s.select_valid;
  assign digital_hold = s.digital_hold;
  assign auto_mode = s.auto_mode;
  assign revertive = s.revertive;
  assign sel_mode = s.mode;
  assign clock_output_enable = s.out_en;
  assign history_delay = s.hist;
  assign drive_one = s.drive_one;
  assign drive_one_valid = s.drive_one_valid;
  assign drive_two = s.drive_two;
  assign drive_two_valid = s.drive_two_valid;

endmodule // input_clock_select_hold_ctrl

// >>> design/clk_sel_pkg.sv
// Constants for the input selection and holdover control block.
// Assumes an 8-bit register port with byte-wide indices.
package clk_sel_pkg;

  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [7:0] ADDR_SEL_HOLD = 8'h03;
  localparam logic [7:0] ADDR_METHOD_HIST = 8'h04;
  localparam logic [7:0] ADDR_CMOS_DRIVE = 8'h05;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_SEL_HOLD = 8'h05;
  localparam logic [7:0] RST_METHOD_HIST = 8'h12;
  localparam logic [7:0] RST_CMOS_DRIVE = 8'hed;

  // ----------------------------------------
  // Writable bit masks
  // ----------------------------------------
  localparam logic [7:0] WMASK_SEL_HOLD = 8'hf0;
  localparam logic [7:0] WMASK_METHOD_HIST = 8'hdf;
  localparam logic [7:0] WMASK_CMOS_DRIVE = 8'hc0;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ACTIVE_SEL_LSB = 6;
  localparam int FORCE_HOLD_BIT = 5;
  localparam int SQUELCH_CAL_BIT = 4;
  localparam int METHOD_LSB = 6;
  localparam int HISTORY_DELAY_LSB = 0;
  localparam int HISTORY_DELAY_W = 5;
  localparam int DRIVE_LSB = 6;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] SEL_INPUT_ONE = 2'h0;
  localparam logic [1:0] SEL_INPUT_TWO = 2'h1;
  localparam logic [1:0] METHOD_MANUAL = 2'h0;
  localparam logic [1:0] METHOD_AUTO_NONREV = 2'h1;
  localparam logic [1:0] METHOD_AUTO_REV = 2'h2;
  localparam logic [2:0] FORMAT_CMOS = 3'h2;

  // Selection modes the block reports
  typedef enum logic [2:0] {
    MODE_MANUAL_REG = 3'b000,
    MODE_MANUAL_PIN = 3'b001,
    MODE_AUTO_NONREV = 3'b010,
    MODE_AUTO_REV = 3'b011,
    MODE_HOLD = 3'b100,
    MODE_RESERVED = 3'b101
  } sel_mode_e;

endpackage

// >>> design/sel_hold_regfile.sv
// Three 8-bit control registers with masked writes and registered reads.
// Assumes one access per cycle on a synchronous byte port.
`timescale 1ns/1ps
module sel_hold_regfile
  import clk_sel_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic [7:0] sel_hold,
  output logic [7:0] method_hist,
  output logic [7:0] cmos_drive
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] sel_hold;
    logic [7:0] method_hist;
    logic [7:0] cmos_drive;
    logic [7:0] rd_data;
  } regs_s;

  regs_s r;
  regs_s next_r;

  // Masked writes keep reserved bits at reset value; reads return stored byte
  always_comb
  begin
    next_r = r;
    if (wr_en)
    begin
      case (addr)
        ADDR_SEL_HOLD: next_r.sel_hold = (wr_data & WMASK_SEL_HOLD) | (RST_SEL_HOLD & ~WMASK_SEL_HOLD);
        ADDR_METHOD_HIST: next_r.method_hist = (wr_data & WMASK_METHOD_HIST)
                                              | (RST_METHOD_HIST & ~WMASK_METHOD_HIST);
        ADDR_CMOS_DRIVE: next_r.cmos_drive = (wr_data & WMASK_CMOS_DRIVE)
                                            | (RST_CMOS_DRIVE & ~WMASK_CMOS_DRIVE);
        default: next_r = r;
      endcase
    end
    if (rd_en)
    begin
      case (addr)
        ADDR_SEL_HOLD: next_r.rd_data = r.sel_hold;
        ADDR_METHOD_HIST: next_r.rd_data = r.method_hist;
        ADDR_CMOS_DRIVE: next_r.rd_data = r.cmos_drive;
        default: next_r.rd_data = 8'h00;
      endcase
    end
  end

  // Register update
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r.sel_hold <= RST_SEL_HOLD;
      r.method_hist <= RST_METHOD_HIST;
      r.cmos_drive <= RST_CMOS_DRIVE;
      r.rd_data <= 8'h00;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign rd_data = r.rd_data;
  assign sel_hold = r.sel_hold;
  assign method_hist = r.method_hist;
  assign cmos_drive = r.cmos_drive;

endmodule // sel_hold_regfile

// >>> test/sel_hold_asserts.sv
// Port checks for the selection and hold control block.
// Assumes the package is compiled first; bound to the top module.
`timescale 1ns/1ps
module sel_hold_checks
  import clk_sel_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rd_data,
  input wire logic select_source_pin_mode,
  input wire logic external_select_pin,
  input wire logic output_always_on,
  input wire logic internal_calibration,
  input wire logic [2:0] output_one_format,
  input wire logic input_select,
  input wire logic select_valid,
  input wire logic digital_hold,
  input wire logic auto_mode,
  input wire logic revertive,
  input wire logic [2:0] sel_mode,
  input wire logic clock_output_enable,
  input wire logic [1:0] drive_one,
  input wire logic drive_one_valid
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  hold_wins_a: assert property (digital_hold |-> sel_mode == MODE_HOLD && !select_valid)
    else $error("hold mode not reported");
  squelch_cal_a: assert property (!internal_calibration || output_always_on |=> clock_output_enable)
    else $error("outputs squelched without cause");
  cmos_valid_a: assert property (output_one_format == FORMAT_CMOS |=> drive_one_valid)
    else $error("cmos drive not valid");
  noncmos_zero_a: assert property (output_one_format != FORMAT_CMOS |=> !drive_one_valid && drive_one == 2'h0)
    else $error("drive code without cmos");
  pin_follow_a: assert property (sel_mode == MODE_MANUAL_PIN && $stable(external_select_pin)
    |-> input_select == external_select_pin)
    else $error("pin choice not followed");
  pin_mode_a: assert property (sel_mode == MODE_MANUAL_PIN |-> $past(select_source_pin_mode))
    else $error("pin mode without pin source");
  revert_flags_a: assert property (sel_mode == MODE_AUTO_REV |-> auto_mode && revertive)
    else $error("revertive flags wrong");
  unmapped_zero_a: assert property (reg_rd_en && (reg_addr < ADDR_SEL_HOLD || reg_addr > ADDR_CMOS_DRIVE)
    |=> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  sel_rsvd_a: assert property (reg_rd_en && reg_addr == ADDR_SEL_HOLD |=> reg_rd_data[3:0] == 4'h5)
    else $error("reserved bits changed");
  cover property (digital_hold);
  cover property (sel_mode == MODE_MANUAL_PIN);
  cover property (!clock_output_enable);
  cover property (sel_mode == MODE_AUTO_REV);
endmodule // sel_hold_checks

bind input_clock_select_hold_ctrl sel_hold_checks u_chk (.clk, .rst_n, .reg_rd_en, .reg_addr, .reg_rd_data,
  .select_source_pin_mode, .external_select_pin, .output_always_on, .internal_calibration, .output_one_format,
  .input_select, .select_valid, .digital_hold, .auto_mode, .revertive, .sel_mode, .clock_output_enable,
  .drive_one, .drive_one_valid);

// >>> test/tb_top.sv
// Self-checking bench for the selection and hold control block.
// Assumes the package, design and checker files are compiled first.
`timescale 1ns/1ps
module tb_top
  import clk_sel_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic pm = 1'b0, ep = 1'b0, ao = 1'b0, cal = 1'b0, ac = 1'b0;
  logic [7:0] ad = 8'h00, wd = 8'h00, rdd;
  logic [2:0] f1 = 3'h1, f2 = 3'h1, sm;
  logic isel, sv, dh, am, rv, coe, d1v, d2v;
  logic [4:0] hd;
  logic [1:0] d1, d2;
  int errors = 0, cmp_count = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  input_clock_select_hold_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(ad),
    .reg_wr_data(wd), .reg_rd_data(rdd), .select_source_pin_mode(pm), .external_select_pin(ep),
    .output_always_on(ao), .internal_calibration(cal), .output_one_format(f1), .output_two_format(f2),
    .auto_choice(ac), .input_select(isel), .select_valid(sv), .digital_hold(dh), .auto_mode(am),
    .revertive(rv), .sel_mode(sm), .clock_output_enable(coe), .history_delay(hd), .drive_one(d1),
    .drive_one_valid(d1v), .drive_two(d2), .drive_two_valid(d2v));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Let input changes reach the outputs
  task automatic step;
    repeat (2) @(negedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    ad = a;
    wd = d;
    @(negedge clk);
    wr = 1'b0;
    step;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd = 1'b1;
    ad = a;
    @(negedge clk);
    rd = 1'b0;
    chk(rdd, exp);
  endtask
  task automatic close_out;
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rreg(ADDR_SEL_HOLD, 8'h05);
    rreg(ADDR_METHOD_HIST, 8'h12);
    rreg(ADDR_CMOS_DRIVE, 8'hed);
    rreg(8'h06, 8'h00);
    chk(hd, 8'h12);
    chk({isel, coe, sm}, 8'h08);
  endtask
  task automatic t_masks;
    wreg(ADDR_SEL_HOLD, 8'hff);
    rreg(ADDR_SEL_HOLD, 8'hf5);
    wreg(ADDR_METHOD_HIST, 8'hff);
    rreg(ADDR_METHOD_HIST, 8'hdf);
    wreg(ADDR_CMOS_DRIVE, 8'h00);
    rreg(ADDR_CMOS_DRIVE, 8'h2d);
    wreg(8'h07, 8'hff);
    rreg(8'h07, 8'h00);
    wreg(ADDR_SEL_HOLD, 8'h00);
    wreg(ADDR_METHOD_HIST, 8'h00);
  endtask
  task automatic t_manual;
    wreg(ADDR_SEL_HOLD, 8'h40);
    chk({isel, sv, sm}, 8'h18);
    wreg(ADDR_SEL_HOLD, 8'h80);
    chk({isel, sv}, 8'h02);
    pm = 1'b1;
    ep = 1'b1;
    step;
    chk({isel, sv, sm}, 8'h19);
    ep = 1'b0;
    step;
    chk({isel, sv}, 8'h01);
    pm = 1'b0;
    wreg(ADDR_SEL_HOLD, 8'h00);
    chk({isel, sv, sm}, 8'h08);
  endtask
  task automatic t_method;
    logic [2:0] mode_tab[4];
    mode_tab = '{MODE_MANUAL_REG, MODE_AUTO_NONREV, MODE_AUTO_REV, MODE_RESERVED};
    // Automatic modes follow the neighbouring selector's choice
    ac = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      wreg(ADDR_METHOD_HIST, {m[1:0], 6'h00});
      chk({isel, am, rv, sm}, {2'h0, m != 0, m == 1 || m == 2, m == 2, mode_tab[m]});
    end
    wreg(ADDR_METHOD_HIST, 8'h80);
    ac = 1'b0;
    step;
    chk({isel, sv, rv}, 8'h03);
    wreg(ADDR_SEL_HOLD, 8'h20);
    chk({dh, sv, sm}, 8'h14);
    wreg(ADDR_SEL_HOLD, 8'h00);
    wreg(ADDR_METHOD_HIST, 8'h0b);
    chk({dh, hd}, 8'h0b);
  endtask
  task automatic t_squelch;
    wreg(ADDR_SEL_HOLD, 8'h10);
    cal = 1'b1;
    step;
    chk(coe, 8'h00);
    ao = 1'b1;
    step;
    chk(coe, 8'h01);
    ao = 1'b0;
    wreg(ADDR_SEL_HOLD, 8'h00);
    chk(coe, 8'h01);
    cal = 1'b0;
  endtask
  task automatic t_drive;
    f1 = FORMAT_CMOS;
    for (int c = 0; c < 4; c++)
    begin
      wreg(ADDR_CMOS_DRIVE, {c[1:0], 6'h00});
      chk({d1v, d1, d2v, d2}, {2'h0, 1'b1, c[1:0], 3'h0});
    end
    f2 = FORMAT_CMOS;
    f1 = 3'h5;
    step;
    chk({d1v, d1, d2v, d2}, 8'h07);
  endtask
  // Reset in mid-run restores the register images
  task automatic t_rearm;
    wreg(ADDR_SEL_HOLD, 8'he0);
    wreg(ADDR_METHOD_HIST, 8'h5f);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rreg(ADDR_SEL_HOLD, 8'h05);
    rreg(ADDR_METHOD_HIST, 8'h12);
    chk({dh, hd}, 8'h12);
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset;
    t_masks;
    t_manual;
    t_method;
    t_squelch;
    t_drive;
    t_rearm;
    close_out;
  end

  // Watchdog against a hang
  initial
  begin
    #20000;
    errors++;
    close_out;
  end
endmodule // tb_top
